// *** common/pllo_pkg.sv ***
package pllo_pkg;
  // Command codes: standard page 0x00xx, extended page 0xFExx
  localparam logic [15:0] CMD_VIN_RD  = 16'h0088;
  localparam logic [15:0] CMD_IIN_RD  = 16'h0089;
  localparam logic [15:0] CMD_VOUT_RD = 16'h008B;
  localparam logic [15:0] CMD_PIN_RD  = 16'h0097;
  localparam logic [15:0] CMD_UNLOCK  = 16'h00D6;
  localparam int          NCFG        = 24;
  // Configuration table, index order fixed by the I_ constants below
  localparam logic [15:0] CFG_ADDR [NCFG] = '{
    16'hFE1C, 16'hFE32, 16'hFE33, 16'hFE34, 16'hFE3B, 16'hFE40,
    16'hFE41, 16'hFE42, 16'hFE44, 16'hFE45, 16'hFE46, 16'hFE47,
    16'hFE48, 16'hFE49, 16'hFE4A, 16'hFE4D, 16'hFE4E, 16'hFE4F,
    16'hFE53, 16'hFE54, 16'hFE7E, 16'hFE7F, 16'hFE8E, 16'hFE8F};
  localparam logic [7:0]  CFG_RST [NCFG] = '{
    8'h40, 8'h20, 8'h00, 8'h00, 8'h10, 8'h00,
    8'h00, 8'h00, 8'h20, 8'hC0, 8'h80, 8'hA0,
    8'h90, 8'hB0, 8'hC0, 8'h10, 8'h08, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Trims that stay closed until the unlock register is written
  localparam logic [NCFG-1:0] CFG_LOCKED = 24'h3C00E0;
  localparam int I_FREQ = 0;
  localparam int I_PTH = 1;
  localparam int I_POFS_LL = 2;
  localparam int I_PGAIN_LL = 3;
  localparam int I_VSCALE = 4;
  localparam int I_LGAIN = 5;
  localparam int I_FBGAIN = 6;
  localparam int I_CGAIN_LO = 7;
  localparam int I_PP1 = 8;
  localparam int I_PP2 = 9;
  localparam int I_VL1 = 10;
  localparam int I_VL2 = 11;
  localparam int I_VH1 = 12;
  localparam int I_VH2 = 13;
  localparam int I_VSH = 14;
  localparam int I_SHHYST = 15;
  localparam int I_PHYST = 16;
  localparam int I_AFE = 17;
  localparam int I_LOFS = 18;
  localparam int I_COFS_LO = 19;
  localparam int I_CGAIN_HI = 20;
  localparam int I_COFS_HI = 21;
  localparam int I_POFS_HL = 22;
  localparam int I_PGAIN_HL = 23;
  // Feature enable bit positions
  localparam int AFE_LOADLINE = 2;
  localparam int AFE_FREQ = 3;
  localparam int AFE_SHED = 4;
  localparam int AFE_FILTER = 5;
  localparam int AFE_FFWD = 6;
  localparam logic [2:0] LL_CYCLES = 3'h4;
  localparam int TRIM_SHIFT = 7;
  localparam int SCALE_SHIFT = 4;
  typedef enum logic [1:0] {LL_LOW, LL_HIGH, LL_SUPER} pllo_line_t;
endpackage

// *** verilog/pllo_optimizer.sv ***
// Behaviour
// - Bit 2 enables load-line setpoint selection
// - Above super-high line, setpoint is flat
// - Super-high comparison uses programmed hysteresis
// - High line interpolates between power points
// - Low line interpolates, clamped outside points
// - Bit 3 enables light-load frequency selection
// - Light frequency below threshold, hysteretic return
// - Bit 5 enables light-load filter selection
// - Light filter only after four line cycles
// - Normal filter restored immediately above hysteresis
// - Shed one PWM phase at light load
// - Bit 4 enables phase shedding
// - Bit 6 enables current-loop feedforward
// - Positive half: first FET switches, second on
// - Negative half: second switches, first on
// - Soft start or bad phase: both switch
// - Line, feedback and current trims write-locked until unlock written
// - Current trim pair follows active range
// - Power trim pair follows line condition
// - Input voltage scaled by divider ratio
`timescale 1ns/100ps
`default_nettype none
module pllo_optimizer
  import pllo_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Register port behind the serial slave
  input  wire logic [15:0] reg_cmd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // Power stage measurements
  input  wire logic [15:0] vin_raw_i,
  input  wire logic [15:0] iin_raw_i,
  input  wire logic [15:0] vout_raw_i,
  input  wire logic [15:0] pin_raw_i,
  input  wire logic [7:0]  line_rms_i,
  input  wire logic [7:0]  power_i,
  input  wire logic [7:0]  low_line_threshold_i,
  input  wire logic [7:0]  high_line_threshold_i,
  input  wire logic        range_750_i,
  input  wire logic        soft_start_i,
  input  wire logic        line_phase_bad_i,
  input  wire logic        bridgeless_i,
  input  wire logic        line_phase_sense_input_i,
  // Setpoints and gate-drive selection
  output logic      [7:0]  vout_setpoint_o,
  output logic             light_freq_sel_o,
  output logic      [7:0]  light_load_frequency_o,
  output logic             light_filter_sel_o,
  output logic             second_phase_en_o,
  output logic             feedforward_en_o,
  output logic             first_boost_fet_switch_o,
  output logic             first_boost_fet_on_o,
  output logic             second_boost_fet_switch_o,
  output logic             second_boost_fet_on_o,
  output logic      [7:0]  cs_gain_o,
  output logic      [7:0]  cs_offset_o
);

  logic [7:0]  cfg [NCFG];
  logic        unlocked;
  logic [4:0]  hit;
  logic [2:0]  psync;
  logic        phase;
  logic        phase_d;
  logic        light;
  logic [2:0]  cycles;
  pllo_line_t  line_sel;
  logic [7:0]  next_setpoint;
  logic [15:0] vin_rd;
  logic [15:0] iin_rd;
  logic [15:0] vout_rd;
  logic [15:0] pin_rd;
  logic [8:0]  pwr_hi;
  logic [8:0]  sh_lo;
  logic [7:0]  afe;

  assign afe = cfg[I_AFE];

  // Table lookup; 31 means no configuration register
  always_comb begin
    hit = 5'h1F;
    for (int k = 0; k < NCFG; k++) begin
      if (reg_cmd_i == CFG_ADDR[k]) begin
        hit = 5'(k);
      end
    end
  end

  // Gain is signed with unity at zero, offset signed
  function automatic logic [15:0] trim(input logic [15:0] r,
                                       input logic [7:0]  g,
                                       input logic [7:0]  o);
    logic signed [25:0] s;
    s = $signed({10'h000, r});
    s = s + ((s * $signed({{18{g[7]}}, g})) >>> TRIM_SHIFT)
          + $signed({{18{o[7]}}, o});
    return s[15:0];
  endfunction

  function automatic logic [7:0] interp(input logic [7:0] v1,
                                        input logic [7:0] v2,
                                        input logic [7:0] p1,
                                        input logic [7:0] p2,
                                        input logic [7:0] p);
    logic signed [17:0] d;
    logic signed [17:0] q;
    d = $signed({10'h000, v2}) - $signed({10'h000, v1});
    q = 18'sh00000;
    if (p <= p1) begin
      return v1;
    end else if (p >= p2) begin
      return v2;
    end
    d = d * $signed({10'h000, 8'(p - p1)});
    q = d / $signed({10'h000, 8'(p2 - p1)});
    return 8'(v1 + q[7:0]);
  endfunction

  // Unmapped commands write nothing and read as zero
  genvar gi;
  generate
    for (gi = 0; gi < NCFG; gi++) begin : g_cfg
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          cfg[gi] <= CFG_RST[gi];
        end else if (reg_wr_i && hit == 5'(gi)
                     && (unlocked || !CFG_LOCKED[gi])) begin
          cfg[gi] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // Lock closes again only through reset
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unlocked <= 1'b0;
    end else if (reg_wr_i && reg_cmd_i == CMD_UNLOCK) begin
      unlocked <= 1'b1;
    end
  end

  always_comb begin
    reg_rdata_o = 16'h0000;
    if (hit != 5'h1F) begin
      reg_rdata_o = {8'h00, cfg[hit]};
    end else begin
      case (reg_cmd_i)
        CMD_VIN_RD:  reg_rdata_o = vin_rd;
        CMD_IIN_RD:  reg_rdata_o = iin_rd;
        CMD_VOUT_RD: reg_rdata_o = vout_rd;
        CMD_PIN_RD:  reg_rdata_o = pin_rd;
        default:     reg_rdata_o = 16'h0000;
      endcase
    end
  end

  // Measurement readings with trims applied
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vin_rd  <= 16'h0000;
      iin_rd  <= 16'h0000;
      vout_rd <= 16'h0000;
      pin_rd  <= 16'h0000;
    end else begin
      vin_rd  <= trim(16'((32'(vin_raw_i) * 32'(cfg[I_VSCALE]))
                          >> SCALE_SHIFT),
                      cfg[I_LGAIN], cfg[I_LOFS]);
      iin_rd  <= trim(iin_raw_i, cs_gain_o, cs_offset_o);
      vout_rd <= trim(vout_raw_i, cfg[I_FBGAIN], 8'h00);
      if (line_sel == LL_LOW) begin
        pin_rd <= trim(pin_raw_i, cfg[I_PGAIN_LL],
                       cfg[I_POFS_LL]);
      end else begin
        pin_rd <= trim(pin_raw_i, cfg[I_PGAIN_HL],
                       cfg[I_POFS_HL]);
      end
    end
  end

  always_comb begin
    cs_gain_o   = range_750_i ? cfg[I_CGAIN_HI] : cfg[I_CGAIN_LO];
    cs_offset_o = range_750_i ? cfg[I_COFS_HI] : cfg[I_COFS_LO];
  end

  // Super-high leaves only below level minus hysteresis; a hysteresis
  // above the level keeps it latched rather than toggling every cycle
  assign sh_lo = {1'b0, cfg[I_VSH]} - {1'b0, cfg[I_SHHYST]};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_sel <= LL_LOW;
    end else begin
      case (line_sel)
        LL_SUPER: begin
          if (!sh_lo[8] && {1'b0, line_rms_i} < sh_lo) begin
            line_sel <= (line_rms_i > high_line_threshold_i)
                        ? LL_HIGH : LL_LOW;
          end
        end
        default: begin
          if (line_rms_i > cfg[I_VSH]) begin
            line_sel <= LL_SUPER;
          end else if (line_rms_i > high_line_threshold_i) begin
            line_sel <= LL_HIGH;
          end else if (line_rms_i < low_line_threshold_i) begin
            line_sel <= LL_LOW;
          end
        end
      endcase
    end
  end

  always_comb begin
    case (line_sel)
      LL_SUPER: next_setpoint = cfg[I_VSH];
      LL_HIGH:  next_setpoint = interp(cfg[I_VH1], cfg[I_VH2],
                                       cfg[I_PP1], cfg[I_PP2],
                                       power_i);
      default:  next_setpoint = interp(cfg[I_VL1], cfg[I_VL2],
                                       cfg[I_PP1], cfg[I_PP2],
                                       power_i);
    endcase
  end

  // Feature off holds the flat high-line upper level
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vout_setpoint_o <= CFG_RST[I_VH2];
    end else if (afe[AFE_LOADLINE]) begin
      vout_setpoint_o <= next_setpoint;
    end else begin
      vout_setpoint_o <= cfg[I_VH2];
    end
  end

  // Light-load condition shared by frequency, filter and shedding
  assign pwr_hi = {1'b0, cfg[I_PTH]} + {1'b0, cfg[I_PHYST]};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      light <= 1'b0;
    end else if (power_i < cfg[I_PTH]) begin
      light <= 1'b1;
    end else if ({1'b0, power_i} > pwr_hi) begin
      light <= 1'b0;
    end
  end

  // Phase pin: three stages, a change counts once stages two and
  // three agree
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      psync <= 3'h0;
      phase <= 1'b0;
      phase_d <= 1'b0;
    end else begin
      psync <= {psync[1:0], line_phase_sense_input_i};
      if (psync[1] == psync[2]) begin
        phase <= psync[2];
      end
      phase_d <= phase;
    end
  end

  // First rising crossing only opens a cycle, so five make four full
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cycles <= 3'h0;
    end else if (!light) begin
      cycles <= 3'h0;
    end else if (phase && !phase_d && cycles != LL_CYCLES + 3'h1) begin
      cycles <= cycles + 3'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      light_freq_sel_o   <= 1'b0;
      light_filter_sel_o <= 1'b0;
      second_phase_en_o  <= 1'b1;
      feedforward_en_o   <= 1'b0;
    end else begin
      light_freq_sel_o   <= afe[AFE_FREQ] && light;
      light_filter_sel_o <= afe[AFE_FILTER] && light
                            && cycles == LL_CYCLES + 3'h1;
      second_phase_en_o  <= !(afe[AFE_SHED] && light);
      feedforward_en_o   <= afe[AFE_FFWD];
    end
  end

  assign light_load_frequency_o = cfg[I_FREQ];

  // Without bridgeless mode both FETs switch together
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_boost_fet_switch_o  <= 1'b1;
      first_boost_fet_on_o      <= 1'b0;
      second_boost_fet_switch_o <= 1'b1;
      second_boost_fet_on_o     <= 1'b0;
    end else if (!bridgeless_i || soft_start_i
                 || line_phase_bad_i) begin
      first_boost_fet_switch_o  <= 1'b1;
      first_boost_fet_on_o      <= 1'b0;
      second_boost_fet_switch_o <= 1'b1;
      second_boost_fet_on_o     <= 1'b0;
    end else begin
      first_boost_fet_switch_o  <= phase;
      second_boost_fet_on_o     <= phase;
      second_boost_fet_switch_o <= !phase;
      first_boost_fet_on_o      <= !phase;
    end
  end

  property p_loadline_off;
    @(posedge mclk_i) disable iff (!rst_b_i)
    !afe[AFE_LOADLINE] |=> vout_setpoint_o == $past(cfg[I_VH2]);
  endproperty
  a_loadline_off: assert property (p_loadline_off)
    else $error("Setpoint moved with load line off");

  property p_super_flat;
    @(posedge mclk_i) disable iff (!rst_b_i)
    afe[AFE_LOADLINE] && line_sel == LL_SUPER
      |=> vout_setpoint_o == $past(cfg[I_VSH]);
  endproperty
  a_super_flat: assert property (p_super_flat)
    else $error("Super high line setpoint not flat");

  property p_super_enter;
    @(posedge mclk_i) disable iff (!rst_b_i)
    line_rms_i > cfg[I_VSH] |=> line_sel == LL_SUPER;
  endproperty
  a_super_enter: assert property (p_super_enter)
    else $error("Super high line not entered");

  property p_clamp_low;
    @(posedge mclk_i) disable iff (!rst_b_i)
    afe[AFE_LOADLINE] && line_sel == LL_LOW && power_i <= cfg[I_PP1]
      |=> vout_setpoint_o == $past(cfg[I_VL1]);
  endproperty
  a_clamp_low: assert property (p_clamp_low)
    else $error("Low line setpoint not clamped");

  property p_clamp_high;
    @(posedge mclk_i) disable iff (!rst_b_i)
    afe[AFE_LOADLINE] && line_sel == LL_HIGH && power_i >= cfg[I_PP2]
      && power_i > cfg[I_PP1]
      |=> vout_setpoint_o == $past(cfg[I_VH2]);
  endproperty
  a_clamp_high: assert property (p_clamp_high)
    else $error("High line setpoint not clamped");

  property p_freq;
    @(posedge mclk_i) disable iff (!rst_b_i)
    afe[AFE_FREQ] && power_i < cfg[I_PTH] ##1 afe[AFE_FREQ]
      |=> light_freq_sel_o;
  endproperty
  a_freq: assert property (p_freq)
    else $error("Light frequency not selected");

  property p_filter_wait;
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(light) |=> !light_filter_sel_o [*2];
  endproperty
  a_filter_wait: assert property (p_filter_wait)
    else $error("Light filter chosen before line cycles");

  property p_filter_back;
    @(posedge mclk_i) disable iff (!rst_b_i)
    $fell(light) |=> !light_filter_sel_o;
  endproperty
  a_filter_back: assert property (p_filter_back)
    else $error("Normal filter not restored at once");

  property p_shed;
    @(posedge mclk_i) disable iff (!rst_b_i)
    !afe[AFE_SHED] |=> second_phase_en_o;
  endproperty
  a_shed: assert property (p_shed)
    else $error("Phase shed while disabled");

  property p_safe_fets;
    @(posedge mclk_i) disable iff (!rst_b_i)
    soft_start_i || line_phase_bad_i
      |=> first_boost_fet_switch_o && second_boost_fet_switch_o;
  endproperty
  a_safe_fets: assert property (p_safe_fets)
    else $error("Both FETs not switching in safe case");

  property p_lock;
    @(posedge mclk_i) disable iff (!rst_b_i)
    !unlocked && reg_wr_i && hit == 5'(I_LGAIN)
      |=> $stable(cfg[I_LGAIN]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("Locked trim was written");

endmodule
`default_nettype wire

// *** tb/pllo_stage_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pllo_stage_model #(
  parameter int HALF = 20
) (
  // Controller clock, used only to pace the line
  input  wire logic        mclk_i,
  // Operating point commanded by the bench
  input  wire logic [7:0]  rms_i,
  input  wire logic [7:0]  power_i,
  // Raw converter values and line phase pin
  output logic      [15:0] vin_raw_o,
  output logic      [15:0] iin_raw_o,
  output logic      [15:0] vout_raw_o,
  output logic      [15:0] pin_raw_o,
  output logic             phase_o
);
  int cnt = 0;
  initial phase_o = 1'b0;
  // Offset from the clock edges so the pin really needs synchronising
  always @(negedge mclk_i) begin
    cnt = (cnt + 1) % HALF;
    if (cnt == 0) begin
      #7 phase_o = ~phase_o;
    end
  end
  assign vin_raw_o  = {8'h00, rms_i};
  assign iin_raw_o  = {2'h0, power_i, 6'h00};
  assign vout_raw_o = 16'h0190;
  assign pin_raw_o  = {4'h0, power_i, 4'h0};
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pllo_pkg::*;
  logic mclk_i = 0, rst_b_i = 0, reg_wr_i = 0, range_750_i = 0;
  logic soft_start_i = 0, line_phase_bad_i = 0, bridgeless_i = 0;
  logic [15:0] reg_cmd_i = 0, reg_rdata_o;
  logic [15:0] vin_raw_i, iin_raw_i, vout_raw_i, pin_raw_i;
  logic [7:0]  reg_wdata_i = 0, line_rms_i = 0, power_i = 0;
  logic [7:0]  low_line_threshold_i = 8'h60, high_line_threshold_i = 8'h90;
  logic [7:0]  vout_setpoint_o, light_load_frequency_o, cs_gain_o, cs_offset_o;
  logic        line_phase_sense_input_i, light_freq_sel_o, light_filter_sel_o;
  logic        second_phase_en_o, feedforward_en_o;
  logic        first_boost_fet_switch_o, first_boost_fet_on_o;
  logic        second_boost_fet_switch_o, second_boost_fet_on_o;
  int          n_mismatch = 0, comparisons = 0;

  always #50 mclk_i = ~mclk_i;

  pllo_stage_model u_stage (.mclk_i, .rms_i(line_rms_i), .power_i,
    .vin_raw_o(vin_raw_i), .iin_raw_o(iin_raw_i), .vout_raw_o(vout_raw_i),
    .pin_raw_o(pin_raw_i), .phase_o(line_phase_sense_input_i));

  pllo_optimizer u_dut (.mclk_i, .rst_b_i, .reg_cmd_i, .reg_wr_i,
    .reg_wdata_i, .reg_rdata_o, .vin_raw_i, .iin_raw_i, .vout_raw_i,
    .pin_raw_i, .line_rms_i, .power_i, .low_line_threshold_i,
    .high_line_threshold_i, .range_750_i, .soft_start_i, .line_phase_bad_i,
    .bridgeless_i, .line_phase_sense_input_i, .vout_setpoint_o,
    .light_freq_sel_o, .light_load_frequency_o, .light_filter_sel_o,
    .second_phase_en_o, .feedforward_en_o, .first_boost_fet_switch_o,
    .first_boost_fet_on_o, .second_boost_fet_switch_o,
    .second_boost_fet_on_o, .cs_gain_o, .cs_offset_o);

  task automatic stop_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] cmd, input logic [7:0] d);
    @(negedge mclk_i);
    reg_cmd_i = cmd;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [15:0] cmd, input logic [15:0] exp);
    @(negedge mclk_i);
    reg_cmd_i = cmd;
    #20 chk(reg_rdata_o, exp);
  endtask

  function automatic logic [15:0] trim(input logic [15:0] r,
                                       input logic [7:0] g,
                                       input logic [7:0] o);
    int p;
    p = (int'(r) * int'($signed(g))) >>> 7;
    return r + p[15:0] + {{8{o[7]}}, o};
  endfunction

  function automatic logic [7:0] lline(input int v1, input int v2,
                                       input int p);
    int p1, p2;
    p1 = CFG_RST[I_PP1];
    p2 = CFG_RST[I_PP2];
    if (p <= p1) return v1[7:0];
    if (p >= p2) return v2[7:0];
    return 8'(v1 + (v2 - v1) * (p - p1) / (p2 - p1));
  endfunction

  // Move the operating point and let the registered paths settle
  task automatic apply(input logic [7:0] rms, input logic [7:0] pw);
    @(negedge mclk_i);
    line_rms_i = rms;
    power_i = pw;
    repeat (4) @(negedge mclk_i);
  endtask

  task automatic fets(input logic [3:0] exp);
    chk({first_boost_fet_switch_o, first_boost_fet_on_o,
         second_boost_fet_switch_o, second_boost_fet_on_o}, exp);
  endtask

  initial begin
    #2_000_000 n_mismatch++;
    stop_test();
  end

  initial begin
    logic [7:0] p, r;
    logic       ph;
    void'($urandom(1577));
    repeat (5) @(negedge mclk_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < NCFG; i++) begin
      rd(CFG_ADDR[i], {8'h00, CFG_RST[i]});
    end
    rd(16'hFE99, 16'h0000);
    wr(16'hFE40, 8'h12);
    rd(16'hFE40, 16'h0000);
    wr(16'hFE34, 8'h40);
    rd(16'hFE34, 16'h0040);
    wr(CMD_UNLOCK, 8'h5A);
    wr(16'hFE40, 8'h12);
    rd(16'hFE40, 16'h0012);
    wr(16'hFE42, 8'h11);
    wr(16'hFE7E, 8'h22);
    wr(16'hFE54, 8'h33);
    wr(16'hFE7F, 8'h44);
    wr(16'hFE8E, 8'h05);
    wr(16'hFE3B, 8'h20);
    for (int k = 0; k < 2; k++) begin
      @(negedge mclk_i);
      range_750_i = k[0];
      apply(8'h30, 8'h9C);
      chk({cs_gain_o, cs_offset_o}, k ? 16'h2244 : 16'h1133);
      rd(CMD_IIN_RD, trim(iin_raw_i, k ? 8'h22 : 8'h11,
                          k ? 8'h44 : 8'h33));
    end
    rd(CMD_VIN_RD, trim(16'h0060, 8'h12, 8'h00));
    rd(CMD_VOUT_RD, 16'h0190);
    wr(16'hFE4F, 8'h04);
    for (int i = 0; i < 14; i++) begin
      p = (i == 0) ? CFG_RST[I_PP1] : (i == 1) ? CFG_RST[I_PP2] : 8'($urandom);
      r = 8'($urandom_range(8'h5F, 0));
      apply(r, p);
      chk(vout_setpoint_o, lline(8'h80, 8'hA0, p));
      rd(CMD_PIN_RD, trim(pin_raw_i, 8'h40, 8'h00));
    end
    for (int i = 0; i < 14; i++) begin
      p = (i == 0) ? CFG_RST[I_PP1] : (i == 1) ? CFG_RST[I_PP2] : 8'($urandom);
      apply(8'($urandom_range(8'hBF, 8'h91)), p);
      chk(vout_setpoint_o, lline(8'h90, 8'hB0, p));
      rd(CMD_PIN_RD, trim(pin_raw_i, 8'h00, 8'h05));
      apply(8'h78, p);
      chk(vout_setpoint_o, lline(8'h90, 8'hB0, p));
    end
    apply(8'h50, 8'h70);
    apply(8'h78, 8'h70);
    chk(vout_setpoint_o, lline(8'h80, 8'hA0, 8'h70));
    apply(8'hC8, 8'h10);
    chk(vout_setpoint_o, 16'h00C0);
    apply(8'hB1, 8'hF0);
    chk(vout_setpoint_o, 16'h00C0);
    apply(8'hAF, 8'hF0);
    chk(vout_setpoint_o, 16'h00B0);
    apply(8'hAF, 8'h20);
    chk(vout_setpoint_o, 16'h0090);
    wr(16'hFE4F, 8'h00);
    apply(8'h40, 8'h10);
    chk(vout_setpoint_o, 16'h00B0);
    repeat (150) @(negedge mclk_i);
    chk({light_freq_sel_o, light_filter_sel_o, second_phase_en_o},
        3'b001);
    chk(feedforward_en_o, 1'b0);
    wr(16'hFE4F, 8'h78);
    apply(8'h40, 8'h40);
    chk(feedforward_en_o, 1'b1);
    chk(light_load_frequency_o, 16'h0040);
    apply(8'h40, 8'h1F);
    chk({light_freq_sel_o, second_phase_en_o}, 2'b10);
    apply(8'h40, 8'h28);
    chk({light_freq_sel_o, second_phase_en_o}, 2'b10);
    repeat (130) @(negedge mclk_i);
    chk(light_filter_sel_o, 1'b0);
    repeat (100) @(negedge mclk_i);
    chk(light_filter_sel_o, 1'b1);
    @(negedge mclk_i);
    power_i = 8'h29;
    repeat (3) @(negedge mclk_i);
    chk({light_freq_sel_o, light_filter_sel_o, second_phase_en_o},
        3'b001);
    bridgeless_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(line_phase_sense_input_i);
      repeat (8) @(negedge mclk_i);
      ph = line_phase_sense_input_i;
      fets(ph ? 4'b1001 : 4'b0110);
    end
    soft_start_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    fets(4'b1010);
    soft_start_i = 1'b0;
    line_phase_bad_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    fets(4'b1010);
    line_phase_bad_i = 1'b0;
    bridgeless_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    fets(4'b1010);
    // Reset in mid-run must close the trim lock again
    @(negedge mclk_i);
    rst_b_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_b_i = 1'b1;
    wr(16'hFE40, 8'h34);
    rd(16'hFE40, {8'h00, CFG_RST[I_LGAIN]});
    stop_test();
  end
endmodule
`default_nettype wire
